// File: tb/pcsil_mac_model.sv
/* client mac model: streams counting bytes on gmii transmit.
   assumes the block's clock and reset. */
`timescale 1ns/1ps
module pcsil_mac_model (
	input  wire logic              clk,
	input  wire logic              rst_b,
	output pcsil_pkg::pcsil_gmii_s gmii_tx
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			gmii_tx <= '0;
		else
			gmii_tx <= '{data: gmii_tx.data + 8'h01, en: 1'b1, er: 1'b0};
	end
endmodule : pcsil_mac_model

// File: tb/tb.sv
/* testbench: register tasks and mode checks.
   covers default build (management, transceiver) and a static-word ten-bit build. */
`timescale 1ns/1ps
`include "pcsil_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	logic                   clk;
	logic                   rst_b;
	logic [3:0]             reg_addr;
	logic [31:0]            reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [31:0]            reg_rdata;
	pcsil_pkg::pcsil_gmii_s gmii_tx;
	pcsil_pkg::pcsil_gmii_s gmii_rx;
	pcsil_pkg::pcsil_cg_s   line_tx;
	logic                   wrap_req;
	logic [1:0]             xcvr_loop_sel;
	int                     mismatches;
	int                     compares;
	int                     cycles;
	logic                   cfg_iso;
	logic                   cfg_loop;
	logic                   rxsrc;
	pcsil_pkg::pcsil_gmii_s tbi_gmii_rx;
	pcsil_pkg::pcsil_cg_s   tbi_line_tx;
	pcsil_pkg::pcsil_cg_s   tbi_line_rx;
	logic                   tbi_wrap;
	logic [1:0]             tbi_loop_sel;
	logic [1:0]             xcvr_lb_in;
	pcsil_mac_model u_mac (.clk(clk), .rst_b(rst_b), .gmii_tx(gmii_tx));
	// serdes loops the line while wrap is requested, else sends idle
	assign tbi_line_rx = tbi_wrap ? tbi_line_tx : '{data: `PCSIL_IDLE_K, is_k: 1'b1};
	// user logic leaves the transceiver loop select on the core output
	assign xcvr_lb_in = xcvr_loop_sel;
	pcsil_ctrl #(.HAS_MGMT(1'b0), .TBI_BUILD(1'b1)) u_dut_tbi (.clk(clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(), .cfg_isolate(cfg_iso), .cfg_loopback(cfg_loop),
		.rx_client_clock_source(1'b0), .gmii_tx(gmii_tx), .gmii_rx(tbi_gmii_rx),
		.line_tx(tbi_line_tx), .line_rx(tbi_line_rx), .wrap_req(tbi_wrap),
		.xcvr_loop_sel(tbi_loop_sel));
	pcsil_ctrl u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cfg_isolate(1'b0), .cfg_loopback(1'b0),
		.rx_client_clock_source(rxsrc), .gmii_tx(gmii_tx), .gmii_rx(gmii_rx),
		.line_tx(line_tx), .line_rx(9'h055), .wrap_req(wrap_req),
		.xcvr_loop_sel(xcvr_loop_sel));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic print_verdict();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
		@(posedge clk);
	endtask : rd
	task automatic chk_pins(input logic iso);
		repeat (4) @(posedge clk);
		#1 `CHK(xcvr_loop_sel, `PCSIL_LOOPSEL_OFF)
		`CHK(wrap_req, 1'b0)
		`CHK(xcvr_lb_in, `PCSIL_LOOPSEL_OFF)
		`CHK(tbi_loop_sel, `PCSIL_LOOPSEL_OFF)
		if (iso) `CHK(gmii_rx, 10'h000)
		@(posedge clk);
	endtask : chk_pins
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		cfg_iso  = 1'b1;
		cfg_loop = 1'b0;
		rxsrc    = 1'b0;
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(`PCSIL_OFF_STAT, 32'h0);
		chk_pins(1'b1);
		#1 `CHK(tbi_gmii_rx, 10'h000)
		`CHK(tbi_wrap, 1'b0)
		@(posedge clk);
		$display("test isolate done");
		rd(4'h8, 32'h0);
		wr(`PCSIL_OFF_CTRL, 32'h0);
		rd(`PCSIL_OFF_STAT, 32'h1);
		chk_pins(1'b0);
		#1 `CHK(line_tx.is_k, 1'b0)
		`CHK(line_tx.data, 8'(gmii_tx.data - 8'h01))
		`CHK(gmii_rx.data, 8'h2a)
		@(posedge clk);
		$display("test release done");
		wr(`PCSIL_OFF_CTRL, 32'h2);
		rd(`PCSIL_OFF_STAT, 32'h7);
		chk_pins(1'b0);
		repeat (2) begin
			#1 `CHK(line_tx.is_k, line_tx.data === `PCSIL_IDLE_K)
			`CHK((line_tx.data === `PCSIL_IDLE_K) || (line_tx.data === 8'h50), 1'b1)
			`CHK(gmii_rx.data, 8'(gmii_tx.data - 8'h01))
			`CHK(gmii_rx.en, 1'b1)
			@(posedge clk);
		end
		$display("test loopback done");
		rxsrc <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`PCSIL_OFF_STAT, 32'h3);
		#1 `CHK(line_tx.is_k, 1'b0)
		`CHK(line_tx.data, 8'(gmii_tx.data - 8'h01))
		@(posedge clk);
		$display("test recovered clock done");
		cfg_iso  <= 1'b0;
		cfg_loop <= 1'b1;
		repeat (8) @(posedge clk);
		#1 `CHK(tbi_wrap, 1'b1)
		`CHK(tbi_gmii_rx.data, 8'(gmii_tx.data - 8'h04))
		`CHK(tbi_gmii_rx.en, 1'b1)
		`CHK(tbi_line_tx.is_k, 1'b0)
		@(posedge clk);
		cfg_iso <= 1'b1;
		repeat (6) @(posedge clk);
		#1 `CHK(tbi_gmii_rx, 10'h000)
		`CHK(tbi_wrap, 1'b0)
		@(posedge clk);
		$display("test ten-bit build done");
		print_verdict();
	end
endmodule : tb

// File: verilog/pcsil_ctrl.sv
/*
 * isolate and loopback control between client gmii and line side.
 * assumes client data on clk; line rx pins are synchronised here; build
 * options are static parameters.
 */
`timescale 1ns/1ps
`include "pcsil_params.svh"

// Behaviour
// - power up isolated from client interface
// - loopback set by management or static word
// - ten-bit build: loopback only raises wrap request
// - transceiver build: tx looped at last point
// - internal loopback sends idle to line
// - transceiver loop select output fixed 00
// - transceiver build: no loopback with recovered rx client clock
module pcsil_ctrl #(
	parameter bit HAS_MGMT  = 1'b1,
	parameter bit TBI_BUILD = 1'b0
) (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic [`PCSIL_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [31:0]                   reg_rdata,
	input  wire logic                     cfg_isolate,
	input  wire logic                     cfg_loopback,
	input  wire logic                     rx_client_clock_source,
	input  wire pcsil_pkg::pcsil_gmii_s   gmii_tx,
	output pcsil_pkg::pcsil_gmii_s        gmii_rx,
	output pcsil_pkg::pcsil_cg_s          line_tx,
	input  wire pcsil_pkg::pcsil_cg_s     line_rx,
	output logic                          wrap_req,
	output logic [1:0]                    xcvr_loop_sel
);

	////////////////////////////////////////////////////////////////////////
	// control register and static word
	logic [1:0]  ctrl;
	logic [1:0]  cfg_s1;
	logic [1:0]  cfg_s2;
	logic        rxsrc_s1;
	logic        rxsrc_s2;
	// line rx pins arrive from the serdes clock
	pcsil_pkg::pcsil_cg_s line_s1;
	pcsil_pkg::pcsil_cg_s line_s2;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_s1   <= `PCSIL_CTRL_RESET;
			cfg_s2   <= `PCSIL_CTRL_RESET;
			rxsrc_s1 <= 1'b0;
			rxsrc_s2 <= 1'b0;
			line_s1  <= '0;
			line_s2  <= '0;
		end else begin
			cfg_s1   <= {cfg_loopback, cfg_isolate};
			cfg_s2   <= cfg_s1;
			rxsrc_s1 <= rx_client_clock_source;
			rxsrc_s2 <= rxsrc_s1;
			line_s1  <= line_rx;
			line_s2  <= line_s1;
		end
	end

	wire wr_ctrl = reg_wr && reg_addr == `PCSIL_OFF_CTRL;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ctrl <= `PCSIL_CTRL_RESET;
		else if (wr_ctrl)
			ctrl <= reg_wdata[1:0];
	end

	wire want_iso  = HAS_MGMT ? ctrl[`PCSIL_BIT_ISOLATE] : cfg_s2[0];
	wire want_loop = HAS_MGMT ? ctrl[`PCSIL_BIT_LOOPBACK] : cfg_s2[1];
	wire loop_ok   = TBI_BUILD || !rxsrc_s2;
	wire int_loop  = want_loop && !TBI_BUILD && loop_ok;

	pcsil_pkg::pcsil_mode_e mode;
	pcsil_pkg::pcsil_mode_e next_mode;

	assign next_mode = want_iso ? pcsil_pkg::PCSIL_ISOLATED :
	                   want_loop ? pcsil_pkg::PCSIL_LOOP : pcsil_pkg::PCSIL_NORMAL;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			mode <= pcsil_pkg::PCSIL_ISOLATED;
		else
			mode <= next_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// datapath
	pcsil_pkg::pcsil_cg_s   idle_cg;
	pcsil_pkg::pcsil_cg_s   tx_cg;
	pcsil_pkg::pcsil_cg_s   rx_cg;
	pcsil_pkg::pcsil_gmii_s next_rx;
	pcsil_pkg::pcsil_cg_s   next_line;
	logic                   idle_phase;
	logic                   isolated;
	logic                   looping;

	assign isolated = mode == pcsil_pkg::PCSIL_ISOLATED;
	assign looping  = mode == pcsil_pkg::PCSIL_LOOP && int_loop;
	assign idle_cg  = idle_phase ? '{data: `PCSIL_IDLE_D, is_k: 1'b0}
	                             : '{data: `PCSIL_IDLE_K, is_k: 1'b1};
	assign tx_cg    = '{data: gmii_tx.data, is_k: 1'b0};
	assign rx_cg    = looping ? tx_cg : line_s2;
	assign next_line = (looping || isolated) ? idle_cg : tx_cg;
	assign next_rx  = isolated ? '0 :
	                  '{data: rx_cg.data, en: looping ? gmii_tx.en : !rx_cg.is_k,
	                    er: looping ? gmii_tx.er : 1'b0};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_phase    <= 1'b0;
			line_tx       <= '{data: `PCSIL_IDLE_K, is_k: 1'b1};
			gmii_rx       <= '0;
			wrap_req      <= 1'b0;
			xcvr_loop_sel <= `PCSIL_LOOPSEL_OFF;
		end else begin
			idle_phase    <= !idle_phase;
			line_tx       <= next_line;
			gmii_rx       <= next_rx;
			wrap_req      <= TBI_BUILD && mode == pcsil_pkg::PCSIL_LOOP;
			xcvr_loop_sel <= `PCSIL_LOOPSEL_OFF;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read
	wire [31:0] rd_mux = reg_addr == `PCSIL_OFF_CTRL ? {30'h0, ctrl} :
	                     reg_addr == `PCSIL_OFF_STAT ? {29'h0, looping, mode} : 32'h0;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// reset and mode selection
	reset_isolated_a: assert property (@(posedge clk) $rose(rst_b) |-> isolated)
		else $error("not isolated after reset");
	reset_outputs_a: assert property (@(posedge clk) $rose(rst_b) |-> gmii_rx == '0)
		else $error("rx active after reset");
	mgmt_release_a: assert property (@(posedge clk) disable iff (!rst_b)
		HAS_MGMT && wr_ctrl && !reg_wdata[0] ##1 !wr_ctrl |=> !isolated)
		else $error("write did not release isolate");
	static_iso_a: assert property (@(posedge clk) disable iff (!rst_b)
		!HAS_MGMT && cfg_s2[0] |=> isolated)
		else $error("static isolate ignored");
	mgmt_loop_a: assert property (@(posedge clk) disable iff (!rst_b)
		HAS_MGMT && wr_ctrl && reg_wdata[1:0] == 2'h2 ##1 !wr_ctrl |=> mode == pcsil_pkg::PCSIL_LOOP)
		else $error("write did not enter loopback");
	static_loop_a: assert property (@(posedge clk) disable iff (!rst_b)
		!HAS_MGMT && cfg_s2 == 2'h2 |=> mode == pcsil_pkg::PCSIL_LOOP)
		else $error("static loopback ignored");

	// loopback per build
	wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
		wrap_req |-> TBI_BUILD)
		else $error("wrap in transceiver build");
	wrap_loop_a: assert property (@(posedge clk) disable iff (!rst_b)
		TBI_BUILD && mode == pcsil_pkg::PCSIL_LOOP |=> wrap_req)
		else $error("wrap missing in loopback");
	wrap_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		mode != pcsil_pkg::PCSIL_LOOP |=> !wrap_req)
		else $error("wrap outside loopback");
	tbi_no_path_a: assert property (@(posedge clk) disable iff (!rst_b)
		TBI_BUILD && mode == pcsil_pkg::PCSIL_LOOP |=> line_tx == $past(tx_cg))
		else $error("internal loop in ten-bit build");
	no_recov_a: assert property (@(posedge clk) disable iff (!rst_b)
		rxsrc_s2 && !TBI_BUILD |-> !int_loop)
		else $error("loopback on recovered clock");
	recov_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
		rxsrc_s2 && !TBI_BUILD && mode == pcsil_pkg::PCSIL_LOOP |=> line_tx == $past(tx_cg))
		else $error("line idle on recovered clock");
	loop_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
		xcvr_loop_sel == 2'b00)
		else $error("loop select not 00");

	// line side
	line_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		looping |=> line_tx == $past(idle_cg))
		else $error("line not idle in loopback");
	idle_alt_a: assert property (@(posedge clk) disable iff (!rst_b)
		looping ##1 looping |=> line_tx.is_k != $past(line_tx.is_k))
		else $error("idle pair not alternating");
	iso_line_a: assert property (@(posedge clk) disable iff (!rst_b)
		isolated |=> line_tx == $past(idle_cg))
		else $error("client tx reached line while isolated");
	normal_tx_a: assert property (@(posedge clk) disable iff (!rst_b)
		mode == pcsil_pkg::PCSIL_NORMAL |=> line_tx == $past(tx_cg))
		else $error("client tx not on line");

	// client side
	rx_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		isolated |=> gmii_rx == '0)
		else $error("rx active while isolated");
	loop_path_a: assert property (@(posedge clk) disable iff (!rst_b)
		looping |=> gmii_rx.data == $past(gmii_tx.data))
		else $error("loop data mismatch");
	loop_en_a: assert property (@(posedge clk) disable iff (!rst_b)
		looping |=> gmii_rx.en == $past(gmii_tx.en))
		else $error("loop enable mismatch");
	rx_line_a: assert property (@(posedge clk) disable iff (!rst_b)
		mode == pcsil_pkg::PCSIL_NORMAL |=> gmii_rx.data == $past(line_s2.data))
		else $error("rx not from line");

endmodule : pcsil_ctrl

// File: verilog/pcsil_params.svh
/*
 * constants for the isolate and loopback control block.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef PCSIL_PARAMS_SVH
`define PCSIL_PARAMS_SVH

`define PCSIL_ADDR_W        4
`define PCSIL_OFF_CTRL      4'h0
`define PCSIL_OFF_STAT      4'h4
`define PCSIL_BIT_ISOLATE   0
`define PCSIL_BIT_LOOPBACK  1
`define PCSIL_CTRL_RESET    2'h1
`define PCSIL_LOOPSEL_OFF   2'h0
`define PCSIL_IDLE_K        8'hbc
`define PCSIL_IDLE_D        8'h50

`endif

// File: verilog/pcsil_pkg.sv
/*
 * types for the isolate and loopback control block.
 * assumes pcsil_params.svh is on the include path.
 */
`include "pcsil_params.svh"

package pcsil_pkg;

	typedef struct packed {
		logic [7:0] data;
		logic       en;
		logic       er;
	} pcsil_gmii_s;

	typedef struct packed {
		logic [7:0] data;
		logic       is_k;
	} pcsil_cg_s;

	typedef enum logic [1:0] {
		PCSIL_ISOLATED = 2'b00,
		PCSIL_NORMAL   = 2'b01,
		PCSIL_LOOP     = 2'b11
	} pcsil_mode_e;

endpackage : pcsil_pkg
